// ===== bench/cpwb_chk.sv
`default_nettype none
module cpwb_chk (
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	input wire logic        cpu_we_i,
	input wire logic [3:0]  cpu_be_i,
	input wire logic [3:0]  cpu_len_i,
	input wire logic        cpu_ack_o,
	input wire logic        cpu_err_o,
	input wire logic        cpu_cycle_accept_n_o,
	input wire logic        pci_req_o,
	input wire logic [3:0]  pci_cmd_o,
	input wire logic [3:0]  pci_be_o,
	input wire logic [2:0]  pci_len_o,
	input wire logic [31:0] pci_taddr_i,
	input wire logic        tgt_claim_o,
	input wire logic        tgt_mem_req_o,
	input wire logic [31:0] tgt_mem_addr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_err_fill; cpu_err_o |-> $past(cpu_len_i) == 4'h8 && !$past(cpu_we_i); endproperty
	a_err_fill: assert property (p_err_fill)
		else $error("refusal without an instruction fill");
	property p_cmd; cpu_ack_o |-> pci_cmd_o[3:1] inside {3'h1, 3'h3}
		&& pci_cmd_o[0] == $past(cpu_we_i); endproperty
	a_cmd: assert property (p_cmd)
		else $error("bus command wrong for access");
	property p_be; cpu_ack_o |-> pci_be_o == ($past(cpu_len_i) == 4'h1 ? $past(cpu_be_i) : 4'hF);
	endproperty
	a_be: assert property (p_be)
		else $error("byte enables wrong");
	property p_len; cpu_ack_o |-> pci_len_o == $past(cpu_len_i[2:0]); endproperty
	a_len: assert property (p_len)
		else $error("word count wrong");
	property p_ack_idle; cpu_ack_o |-> !$past(pci_req_o); endproperty
	a_ack_idle: assert property (p_ack_idle)
		else $error("access taken while buffer busy");
	// Accept drops on the edge that also raises the request for the full write
	property p_full; $rose(cpu_cycle_accept_n_o) |-> pci_req_o && pci_cmd_o[0]
		&& pci_len_o == 3'h4; endproperty
	a_full: assert property (p_full)
		else $error("accept dropped without a pending full write");
	property p_tgt_low; tgt_mem_req_o |-> tgt_claim_o
		&& tgt_mem_addr_o[20:0] == pci_taddr_i[20:0]; endproperty
	a_tgt_low: assert property (p_tgt_low)
		else $error("target low address not passed");
	property p_tgt_gap; tgt_mem_req_o |=> !tgt_mem_req_o [*4]; endproperty
	a_tgt_gap: assert property (p_tgt_gap)
		else $error("second memory request for one sample");
endmodule
bind cpwb_top cpwb_chk i_chk (.*);
`default_nettype wire

// ===== bench/cpwb_pci_model.sv
`default_nettype none
module cpwb_pci_model (
	input  wire logic        req_i,
	input  wire logic [3:0]  cmd_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [2:0]  len_i,
	input  wire logic [3:0]  slow_i,
	input  wire logic        tval_i,
	input  wire logic [31:0] tadr_i,
	output logic             clk_o,
	output logic             gnt_o,
	output logic             rvld_o,
	output logic [31:0]      rdat_o,
	output logic             tvld_o,
	output logic [31:0]      tadr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_r;
	logic [2:0] cnt_r;
	initial begin
		{clk_o, gnt_o, rvld_o, rdat_o, tvld_o, tadr_o} = '0;
		#3;
		forever #40 clk_o = ~clk_o;
	end
	always @(posedge clk_o) begin
		rvld_o <= 1'b0;
		// Idle lines never repeat the last word, so a stale sample shows
		rdat_o <= ~rdat_o;
		tvld_o <= tval_i;
		tadr_o <= tval_i ? tadr_i : ~tadr_o;
		if (!req_i) begin
			gnt_o  <= 1'b0;
			wait_r <= slow_i;
			cnt_r  <= 3'h0;
		end else if (wait_r != 4'h0) begin
			wait_r <= wait_r - 4'h1;
		end else begin
			gnt_o <= 1'b1;
			if (gnt_o && !cmd_i[0] && cnt_r != len_i) begin
				rvld_o <= 1'b1;
				rdat_o <= adr_i + {cnt_r, 2'b00};
				cnt_r  <= cnt_r + 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== bench/test_cpu_pci_window_bridge.sv
`include "cpwb_regs.vh"
`default_nettype none
`define CHK(e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %0t exp %h got %h", $time, e, g); end end
module test_cpu_pci_window_bridge;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, tval = 0, go = 0;
	logic cpu_req_i = 0, cpu_we_i = 0, cpu_wvalid_i = 0, cpu_rready_i = 0;
	logic [7:0] reg_addr_i = 0;
	logic [31:0] reg_wdata_i = 0, cpu_addr_i = 0, cpu_wdata_i = 0, tadr = 0, a;
	logic [3:0] cpu_be_i = 0, cpu_len_i = 0, slow = 0, len;
	wire logic cpu_ack_o, cpu_local_o, cpu_err_o, cpu_cycle_accept_n_o, cpu_rvalid_o;
	wire logic pci_clk_i, pci_gnt_i, pci_rvalid_i, pci_req_o, pci_wvalid_o, pci_tvalid_i;
	wire logic tgt_claim_o, tgt_mem_req_o;
	wire logic [31:0] reg_rdata_o, cpu_rdata_o, pci_rdata_i, pci_addr_o, pci_wdata_o;
	wire logic [31:0] pci_taddr_i, tgt_mem_addr_o;
	wire logic [3:0] pci_cmd_o, pci_be_o;
	wire logic [2:0] pci_len_o;
	int bad_count = 0, n_tests = 0, cyc = 0, claims = 0, n;
	logic [31:0] win[5] = '{default: 0}, ew[$];
	logic [7:0] offs[5] = '{`CPWB_OFS_MWIN1, `CPWB_OFS_MWIN2, `CPWB_OFS_TWIN1,
		`CPWB_OFS_TWIN2, `CPWB_OFS_MIOWIN};
	logic [7:0] sel[5] = '{8'h40, 8'h41, 8'h60, 8'h70, 8'h12};
	logic [32:0] tm;
	cpwb_top i_dut (.*);
	cpwb_pci_model i_pci (.req_i(pci_req_o), .cmd_i(pci_cmd_o), .adr_i(pci_addr_o),
		.len_i(pci_len_o), .slow_i(slow), .tval_i(tval), .tadr_i(tadr), .clk_o(pci_clk_i),
		.gnt_o(pci_gnt_i), .rvld_o(pci_rvalid_i), .rdat_o(pci_rdata_i),
		.tvld_o(pci_tvalid_i), .tadr_o(pci_taddr_i));
	always #5 core_clk_i = ~core_clk_i;
	function automatic logic [32:0] mmap(input logic [31:0] w, input logic [31:0] x);
		logic [7:0] c;
		c = {1'b1, w[19:13]};
		mmap = {w[12] && ((w[31:24] ^ x[31:24]) & c) == 8'h00,
			(w[7:0] & c) | (x[31:24] & ~c), x[23:0]};
	endfunction
	function automatic logic [32:0] tmap(input logic [31:0] w, input logic [31:0] x);
		logic [10:0] c;
		c = {4'hF, w[19:13]};
		tmap = {w[12] && ((w[31:21] ^ x[31:21]) & c) == 11'h000,
			(w[10:0] & c) | (x[31:21] & ~c), x[20:0]};
	endfunction
	task automatic print_verdict();
		if (bad_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		reg_addr_i = ad;
		reg_wdata_i = d;
		reg_wr_i = 1;
		@(posedge core_clk_i) #1 reg_wr_i = 0;
		@(posedge core_clk_i) #1;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		reg_addr_i = ad;
		reg_rd_i = 1;
		@(posedge core_clk_i) #1 reg_rd_i = 0;
		@(posedge core_clk_i) #1;
		`CHK(e, reg_rdata_o)
	endtask
	// Windows are only rewritten while the master path is idle
	task automatic setw(input int i, input logic [31:0] d);
		win[i] = d & ((i == 2 || i == 3) ? `CPWB_TWIN_WMASK : `CPWB_MWIN_WMASK);
		wr(offs[i], d);
		rd(offs[i], win[i]);
	endtask
	task automatic cpu(input logic we, input logic [31:0] x, input logic [3:0] ln,
		input logic [3:0] be);
		logic [32:0] m, t;
		logic [31:0] pa;
		logic io;
		int i, k;
		m = 0;
		io = 0;
		for (i = 0; i < 5; i++) begin
			t = mmap(win[i], x);
			if ((i < 2 || i == 4) && t[32]) begin
				m = t;
				io = (i == 4);
			end
		end
		cpu_we_i = we;
		cpu_addr_i = x;
		cpu_len_i = ln;
		cpu_be_i = be;
		cpu_req_i = 1;
		k = 0;
		do begin
			@(posedge core_clk_i) #1 k++;
		end while (!(cpu_ack_o | cpu_local_o | cpu_err_o) && k < 400);
		cpu_req_i = 0;
		`CHK((ln == 8 && !we) ? 3'h4 : m[32] ? 3'h2 : 3'h1,
			{cpu_err_o, cpu_ack_o, cpu_local_o})
		if (cpu_ack_o === 1'b1) begin
			pa = (!we && ln == 4) ? {m[31:4], 4'h0} : m[31:0];
			`CHK({pa, 1'b0, ~io, 1'b1, we}, {pci_addr_o, pci_cmd_o})
			for (i = 0; i < ln; i++) begin
				if (we) begin
					cpu_wdata_i = $urandom;
					ew.push_back(cpu_wdata_i);
					cpu_wvalid_i = 1;
					@(posedge core_clk_i) #1;
				end else begin
					for (k = 0; k < 400 && !(cpu_rvalid_o && cpu_rready_i); k++)
						@(posedge core_clk_i) #1 cpu_rready_i = 1'($urandom);
					`CHK(pa + (ln == 4 ? ((x[3:2] + i) & 3) * 4 : i * 4), cpu_rdata_o)
					@(posedge core_clk_i) #1 cpu_rready_i = 1'($urandom);
				end
			end
			cpu_wvalid_i = 0;
			if (we && ln == 4) begin
				repeat (2) @(posedge core_clk_i);
				#1 `CHK(1'b1, cpu_cycle_accept_n_o)
			end
		end
		@(posedge core_clk_i) #1;
	endtask
	always @(posedge pci_clk_i) if (pci_wvalid_o === 1'b1) `CHK(ew.pop_front(), pci_wdata_o)
	always #80 begin
		tadr = $urandom;
		tadr[31:25] = tadr[1] ? 7'h10 : 7'h40;
		tval = go && tadr[0];
	end
	always @(negedge core_clk_i) begin
		cyc++;
		if (tgt_mem_req_o === 1'b1) begin
			tm = tmap(win[2], pci_taddr_i);
			if (!tm[32]) tm = tmap(win[3], pci_taddr_i);
			`CHK({1'b1, tm[31:0]}, {tm[32], tgt_mem_addr_o})
			claims++;
		end
		if (cyc == 50000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(32'h5681c025));
		repeat (16) @(posedge core_clk_i);
		#1 rst_i = 0;
		for (n = 0; n < 5; n++) rd(offs[n], `CPWB_WIN_RESET);
		rd(8'h28, 32'h0);
		setw(0, 32'h40FFDF81);
		setw(1, 32'h60FFE022);
		setw(4, 32'h700FF005);
		setw(2, 32'h201E1FA5);
		setw(3, 32'h800FE011);
		go = 1;
		cpu(0, 32'h60000010, 4'h1, 4'h3);
		setw(1, 32'h600FF022);
		cpu(0, 32'h41000008, 4'h8, 4'hF);
		slow = 4'hF;
		cpu(1, 32'h40123450, 4'h4, 4'hF);
		cpu(0, 32'h12000000, 4'h1, 4'h1);
		cpu(1, 32'h70000100, 4'h4, 4'hF);
		cpu(0, 32'h41000028, 4'h4, 4'hF);
		for (n = 0; n < 40; n++) begin
			slow = 4'($urandom);
			a = $urandom;
			a[1:0] = 2'h0;
			a[31:24] = sel[$urandom % 5];
			len = 4'($urandom_range(4, 1));
			cpu(1'($urandom), a, len, len == 1 ? 4'($urandom_range(15, 1)) : 4'hF);
		end
		for (n = 0; n < 3000 && (pci_req_o !== 1'b0 || ew.size() != 0); n++)
			@(posedge core_clk_i);
		`CHK(0, ew.size())
		`CHK(1'b1, claims > 0)
		print_verdict();
	end
endmodule
`default_nettype wire

// ===== design/cpwb_mem.v
`default_nettype none
module cpwb_mem #(
	parameter W     = 32,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire          core_clk_i,
	input  wire          rst_i,
	input  wire          we_i,
	input  wire [AW-1:0] waddr_i,
	input  wire [W-1:0]  wdata_i,
	input  wire [AW-1:0] raddr_i,
	output reg  [W-1:0]  rdata_o
);
	reg [W-1:0] mem_r [0:DEPTH-1];

	// Storage has no reset; only the read register is cleared
	always @(posedge core_clk_i) begin
		if (we_i) begin
			mem_r[waddr_i] <= wdata_i;
		end
	end

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= {W{1'b0}};
		end else begin
			rdata_o <= mem_r[raddr_i];
		end
	end
endmodule
`default_nettype wire

// ===== design/cpwb_regs.vh
`ifndef CPWB_REGS_VH
`define CPWB_REGS_VH

`define CPWB_OFS_MWIN1     8'h14
`define CPWB_OFS_MWIN2     8'h18
`define CPWB_OFS_TWIN1     8'h1C
`define CPWB_OFS_TWIN2     8'h20
`define CPWB_OFS_MIOWIN    8'h24
`define CPWB_WIN_RESET     32'h00000000
`define CPWB_MWIN_WMASK    32'hFF0FF0FF
`define CPWB_TWIN_WMASK    32'hFFEFF7FF

`define CPWB_EN_BIT        12
`define CPWB_MASK_LSB      13
`define CPWB_MASK_MSB      19
`define CPWB_MRB_MSB       7
`define CPWB_MLB_LSB       24
`define CPWB_TLB_MSB       10
`define CPWB_TPB_LSB       21

`define CPWB_CMD_IORD      4'h2
`define CPWB_CMD_IOWR      4'h3
`define CPWB_CMD_MEMRD     4'h6
`define CPWB_CMD_MEMWR     4'h7

`define CPWB_FIFO_WORDS    3'h4
`define CPWB_ICACHE_WORDS  4'h8
`define CPWB_WIN_SETTLE    2

`endif

// ===== design/cpwb_skid.v
`default_nettype none
module cpwb_skid #(
	parameter W = 32
) (
	input  wire         core_clk_i,
	input  wire         rst_i,
	input  wire         in_valid_i,
	input  wire [W-1:0] in_data_i,
	output wire         in_ready_o,
	output reg          out_valid_o,
	output reg  [W-1:0] out_data_o,
	input  wire         out_ready_i
);
	reg         v1_r;
	reg [W-1:0] d1_r;
	wire        pop  = out_valid_o & out_ready_i;
	wire        push = in_valid_i & ~v1_r;

	assign in_ready_o = ~v1_r;

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_valid_o <= 1'b0;
			out_data_o  <= {W{1'b0}};
			v1_r        <= 1'b0;
			d1_r        <= {W{1'b0}};
		end else if (pop) begin
			if (v1_r) begin
				out_data_o <= d1_r;
				v1_r       <= push;
				if (push) begin
					d1_r <= in_data_i;
				end
			end else begin
				out_valid_o <= push;
				if (push) begin
					out_data_o <= in_data_i;
				end
			end
		end else if (push) begin
			if (out_valid_o) begin
				v1_r <= 1'b1;
				d1_r <= in_data_i;
			end else begin
				out_valid_o <= 1'b1;
				out_data_o  <= in_data_i;
			end
		end
	end
endmodule
`default_nettype wire

// ===== design/cpwb_top.v
`include "cpwb_regs.vh"
`default_nettype none
module cpwb_top (
	input  wire        core_clk_i,
	input  wire        rst_i,
	// Register port
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	input  wire [7:0]  reg_addr_i,
	input  wire [31:0] reg_wdata_i,
	output reg  [31:0] reg_rdata_o,
	// CPU side
	input  wire        cpu_req_i,
	input  wire        cpu_we_i,
	input  wire [31:0] cpu_addr_i,
	input  wire [3:0]  cpu_be_i,
	input  wire [3:0]  cpu_len_i,
	output reg         cpu_ack_o,
	output reg         cpu_local_o,
	output reg         cpu_err_o,
	output reg         cpu_cycle_accept_n_o,
	input  wire        cpu_wvalid_i,
	input  wire [31:0] cpu_wdata_i,
	output wire        cpu_rvalid_o,
	output wire [31:0] cpu_rdata_o,
	input  wire        cpu_rready_i,
	// PCI master side
	input  wire        pci_clk_i,
	input  wire        pci_gnt_i,
	input  wire        pci_rvalid_i,
	input  wire [31:0] pci_rdata_i,
	output reg         pci_req_o,
	output reg  [3:0]  pci_cmd_o,
	output reg  [31:0] pci_addr_o,
	output reg  [3:0]  pci_be_o,
	output reg  [2:0]  pci_len_o,
	output reg         pci_wvalid_o,
	output reg  [31:0] pci_wdata_o,
	// PCI target side
	input  wire        pci_tvalid_i,
	input  wire [31:0] pci_taddr_i,
	output reg         tgt_claim_o,
	output reg         tgt_mem_req_o,
	output reg  [31:0] tgt_mem_addr_o
);
	localparam ST_IDLE  = 2'h0;
	localparam ST_WFILL = 2'h1;
	localparam ST_WXFER = 2'h2;
	localparam ST_RD    = 2'h3;
	localparam SW       = 68;

	function mhit;
		input [31:0] w;
		input [7:0]  a;
		begin
			mhit = w[`CPWB_EN_BIT] & (((a ^ w[31:`CPWB_MLB_LSB])
				& {1'b1, w[`CPWB_MASK_MSB:`CPWB_MASK_LSB]}) == 8'h00);
		end
	endfunction

	function [7:0] mxlt;
		input [31:0] w;
		input [7:0]  a;
		reg   [7:0]  cm;
		begin
			cm   = {1'b1, w[`CPWB_MASK_MSB:`CPWB_MASK_LSB]};
			mxlt = (w[`CPWB_MRB_MSB:0] & cm) | (a & ~cm);
		end
	endfunction

	function thit;
		input [31:0] w;
		input [10:0] a;
		begin
			thit = w[`CPWB_EN_BIT] & (((a ^ w[31:`CPWB_TPB_LSB])
				& {4'hF, w[`CPWB_MASK_MSB:`CPWB_MASK_LSB]}) == 11'h000);
		end
	endfunction

	function [10:0] txlt;
		input [31:0] w;
		input [10:0] a;
		reg   [10:0] cm;
		begin
			cm   = {4'hF, w[`CPWB_MASK_MSB:`CPWB_MASK_LSB]};
			txlt = (w[`CPWB_TLB_MSB:0] & cm) | (a & ~cm);
		end
	endfunction

	reg  [31:0] mwin1_r;
	reg  [31:0] mwin2_r;
	reg  [31:0] mio_r;
	reg  [31:0] twin1_r;
	reg  [31:0] twin2_r;
	reg  [SW-1:0] sync1_r;
	reg  [SW-1:0] sync2_r;
	reg  [1:0]  st_r;
	reg  [2:0]  len_r;
	reg         line_r;
	reg  [1:0]  start_r;
	reg  [2:0]  k_r;
	reg  [2:0]  ret_r;
	reg  [3:0]  vld_r;
	reg         rd_pend_r;
	reg         clk_d_r;

	// Link pins pass two flops; the PCI clock is watched for its falling edge,
	// halfway between the partner's launch edges, so sampled data is settled.
	wire        s_clk    = sync2_r[67];
	wire        gnt_s    = sync2_r[66];
	wire        rvalid_s = sync2_r[65];
	wire        tvalid_s = sync2_r[64];
	wire [31:0] rdata_s  = sync2_r[63:32];
	wire [31:0] taddr_s  = sync2_r[31:0];
	wire        pci_tick = clk_d_r & ~s_clk;

	wire        h1   = mhit(mwin1_r, cpu_addr_i[31:24]);
	wire        h2   = mhit(mwin2_r, cpu_addr_i[31:24]);
	wire        hio  = mhit(mio_r, cpu_addr_i[31:24]);
	wire        hany = h1 | h2 | hio;
	wire [31:0] hwin = h1 ? mwin1_r : (h2 ? mwin2_r : mio_r);
	wire        busy = cpu_ack_o | cpu_local_o | cpu_err_o;
	wire        take = cpu_req_i & ~busy;
	wire        fill = ~cpu_we_i & (cpu_len_i == {1'b0, `CPWB_FIFO_WORDS});
	wire        th1  = thit(twin1_r, taddr_s[31:21]);
	wire        th2  = thit(twin2_r, taddr_s[31:21]);

	wire [1:0]  ridx     = line_r ? (start_r + ret_r[1:0]) : ret_r[1:0];
	wire        k_done   = (k_r == len_r);
	wire        wr_cpu   = (st_r == ST_WFILL) & cpu_wvalid_i & ~k_done;
	wire        wr_pci   = (st_r == ST_RD) & pci_tick & gnt_s & rvalid_s & ~k_done;
	wire        mem_we   = wr_cpu | wr_pci;
	wire [31:0] mem_wd   = wr_cpu ? cpu_wdata_i : rdata_s;
	wire [1:0]  mem_ra   = (st_r == ST_RD) ? ridx : k_r[1:0];
	wire [31:0] mem_rd;
	wire        skid_rdy;
	wire        issue    = (st_r == ST_RD) & ~rd_pend_r & (ret_r != len_r)
				& vld_r[ridx] & skid_rdy;

	cpwb_mem #(.W(32), .DEPTH(4), .AW(2)) u_mem (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.we_i       (mem_we),
		.waddr_i    (k_r[1:0]),
		.wdata_i    (mem_wd),
		.raddr_i    (mem_ra),
		.rdata_o    (mem_rd)
	);

	cpwb_skid #(.W(32)) u_skid (
		.core_clk_i  (core_clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (rd_pend_r),
		.in_data_i   (mem_rd),
		.in_ready_o  (skid_rdy),
		.out_valid_o (cpu_rvalid_o),
		.out_data_o  (cpu_rdata_o),
		.out_ready_i (cpu_rready_i)
	);

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_r <= {SW{1'b0}};
			sync2_r <= {SW{1'b0}};
			clk_d_r <= 1'b0;
		end else begin
			sync1_r <= {pci_clk_i, pci_gnt_i, pci_rvalid_i, pci_tvalid_i,
				pci_rdata_i, pci_taddr_i};
			sync2_r <= sync1_r;
			clk_d_r <= s_clk;
		end
	end

	// Window registers; reserved bits never store a one
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mwin1_r     <= `CPWB_WIN_RESET;
			mwin2_r     <= `CPWB_WIN_RESET;
			mio_r       <= `CPWB_WIN_RESET;
			twin1_r     <= `CPWB_WIN_RESET;
			twin2_r     <= `CPWB_WIN_RESET;
			reg_rdata_o <= 32'h00000000;
		end else begin
			if (reg_wr_i) begin
				case (reg_addr_i)
				`CPWB_OFS_MWIN1: mwin1_r <= reg_wdata_i & `CPWB_MWIN_WMASK;
				`CPWB_OFS_MWIN2: mwin2_r <= reg_wdata_i & `CPWB_MWIN_WMASK;
				`CPWB_OFS_MIOWIN: mio_r <= reg_wdata_i & `CPWB_MWIN_WMASK;
				`CPWB_OFS_TWIN1: twin1_r <= reg_wdata_i & `CPWB_TWIN_WMASK;
				`CPWB_OFS_TWIN2: twin2_r <= reg_wdata_i & `CPWB_TWIN_WMASK;
				default: ;
				endcase
			end
			if (reg_rd_i) begin
				case (reg_addr_i)
				`CPWB_OFS_MWIN1: reg_rdata_o <= mwin1_r;
				`CPWB_OFS_MWIN2: reg_rdata_o <= mwin2_r;
				`CPWB_OFS_MIOWIN: reg_rdata_o <= mio_r;
				`CPWB_OFS_TWIN1: reg_rdata_o <= twin1_r;
				`CPWB_OFS_TWIN2: reg_rdata_o <= twin2_r;
				default: reg_rdata_o <= 32'h00000000;
				endcase
			end
		end
	end

	// Target decode runs apart from the master state, so a waiting master
	// request never blocks another agent from reaching local memory.
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tgt_claim_o    <= 1'b0;
			tgt_mem_req_o  <= 1'b0;
			tgt_mem_addr_o <= 32'h00000000;
		end else begin
			tgt_mem_req_o <= 1'b0;
			if (pci_tick) begin
				tgt_claim_o <= tvalid_s & (th1 | th2);
				if (tvalid_s & (th1 | th2)) begin
					tgt_mem_req_o  <= 1'b1;
					tgt_mem_addr_o <= {txlt(th1 ? twin1_r : twin2_r, taddr_s[31:21]),
						taddr_s[20:0]};
				end
			end
		end
	end

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r                 <= ST_IDLE;
			len_r                <= 3'h0;
			line_r               <= 1'b0;
			start_r              <= 2'h0;
			k_r                  <= 3'h0;
			ret_r                <= 3'h0;
			vld_r                <= 4'h0;
			rd_pend_r            <= 1'b0;
			cpu_ack_o            <= 1'b0;
			cpu_local_o          <= 1'b0;
			cpu_err_o            <= 1'b0;
			cpu_cycle_accept_n_o <= 1'b0;
			pci_req_o            <= 1'b0;
			pci_cmd_o            <= 4'h0;
			pci_addr_o           <= 32'h00000000;
			pci_be_o             <= 4'h0;
			pci_len_o            <= 3'h0;
			pci_wvalid_o         <= 1'b0;
			pci_wdata_o          <= 32'h00000000;
		end else begin
			cpu_ack_o   <= 1'b0;
			cpu_local_o <= 1'b0;
			cpu_err_o   <= 1'b0;
			rd_pend_r   <= issue;
			if (take) begin
				if (!hany) begin
					cpu_local_o <= 1'b1;
				end else if (st_r == ST_IDLE) begin
					if (!cpu_we_i && cpu_len_i == `CPWB_ICACHE_WORDS) begin
						cpu_err_o <= 1'b1;
					end else begin
						cpu_ack_o  <= 1'b1;
						len_r      <= cpu_len_i[2:0];
						pci_len_o  <= cpu_len_i[2:0];
						line_r     <= fill;
						start_r    <= cpu_addr_i[3:2];
						k_r        <= 3'h0;
						ret_r      <= 3'h0;
						vld_r      <= 4'h0;
						pci_addr_o <= {mxlt(hwin, cpu_addr_i[31:24]), cpu_addr_i[23:4],
							fill ? 2'b00 : cpu_addr_i[3:2], cpu_addr_i[1:0]};
						pci_be_o   <= (cpu_len_i == 4'h1) ? cpu_be_i : 4'hF;
						if (hio) begin
							pci_cmd_o <= cpu_we_i ? `CPWB_CMD_IOWR : `CPWB_CMD_IORD;
						end else begin
							pci_cmd_o <= cpu_we_i ? `CPWB_CMD_MEMWR : `CPWB_CMD_MEMRD;
						end
						if (cpu_we_i) begin
							st_r <= ST_WFILL;
						end else begin
							st_r      <= ST_RD;
							pci_req_o <= 1'b1;
						end
					end
				end
			end
			case (st_r)
			ST_WFILL: begin
				if (wr_cpu) begin
					k_r <= k_r + 3'h1;
				end
				if (k_done) begin
					k_r       <= 3'h0;
					pci_req_o <= 1'b1;
					st_r      <= ST_WXFER;
				end
			end
			ST_WXFER: begin
				// Each falling PCI edge with the grant seen presents the next word for the next rise
				if (pci_tick && gnt_s) begin
					if (!k_done) begin
						pci_wdata_o  <= mem_rd;
						pci_wvalid_o <= 1'b1;
						k_r          <= k_r + 3'h1;
					end else begin
						pci_wvalid_o <= 1'b0;
						pci_req_o    <= 1'b0;
						st_r         <= ST_IDLE;
					end
				end
			end
			ST_RD: begin
				if (wr_pci) begin
					k_r          <= k_r + 3'h1;
					vld_r[k_r[1:0]] <= 1'b1;
				end
				if (k_done) begin
					pci_req_o <= 1'b0;
				end
				if (issue) begin
					ret_r <= ret_r + 3'h1;
				end
				if (k_done && ret_r == len_r && !rd_pend_r) begin
					st_r <= ST_IDLE;
				end
			end
			default: ;
			endcase
			// Negated while the buffer sits full and the bus is not yet ours
			cpu_cycle_accept_n_o <= ~gnt_s & (((st_r == ST_WFILL) && (k_r == `CPWB_FIFO_WORDS))
				|| ((st_r == ST_WXFER) && (k_r == 3'h0) && (len_r == `CPWB_FIFO_WORDS)));
		end
	end
endmodule
`default_nettype wire
